//--- rtl/frnp_lookahead.sv
// Look-ahead read sequencer for the flash block: serves 32-bit reads from a
// block buffer and fetches the predicted next block from the array meanwhile.
// Assumes an array that presents a block on arr_rdata a fixed number of
// cycles after arr_rd rises or arr_addr changes while it stays high, and a requester on the same clock.
`timescale 1ns/1ps
`include "frnp_regs.svh"

module frnp_lookahead #(
	parameter int WORD_W = `FRNP_WORD_W,
	parameter int BLOCK_W = `FRNP_BLOCK_W,
	parameter int PAGE_W = `FRNP_PAGE_W,
	parameter int SECTOR_W = `FRNP_SECTOR_W,
	parameter int DATA_W = `FRNP_DATA_W,
	parameter int TAG_W = 2 + SECTOR_W + PAGE_W + BLOCK_W,
	parameter int LINE_W = DATA_W << WORD_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic pipe_mode,
	input wire logic rd_req,
	input wire logic req_aux,
	input wire logic req_spare,
	input wire logic [SECTOR_W-1:0] req_sector,
	input wire logic [PAGE_W-1:0] req_page,
	input wire logic [BLOCK_W-1:0] req_block,
	input wire logic [WORD_W-1:0] req_word,
	output logic busy,
	output logic [DATA_W-1:0] rdata,
	output logic rdata_valid,
	output logic arr_rd,
	output logic [TAG_W-1:0] arr_addr,
	input wire logic [LINE_W-1:0] arr_rdata
);

	frnp_pkg::frnp_state_t state;
	frnp_pkg::frnp_state_t next_state;

	logic [3:0] cnt;
	logic rd_done;
	logic [TAG_W-1:0] req_tag;
	logic [TAG_W-1:0] buf_tag;
	logic [LINE_W-1:0] buf_data;
	logic buf_valid;
	logic [TAG_W-1:0] la_tag;
	logic [LINE_W-1:0] la_data;
	logic la_valid;
	logic [TAG_W-1:0] pred_tag;
	logic [SECTOR_W-1:0] pred_sector;
	logic [PAGE_W-1:0] pred_page;
	logic [BLOCK_W-1:0] pred_block;
	logic buf_hit;
	logic la_hit;
	logic serve;
	logic swap;
	logic miss;
	logic need_pref;
	logic [DATA_W-1:0] word_sel;
	logic [DATA_W-1:0] stage_data;
	logic stage_valid;

	assign req_tag = {req_aux, req_spare, req_sector, req_page, req_block};
	assign rd_done = (cnt == 4'h1);
	assign arr_rd = (state != frnp_pkg::FRNP_IDLE);

	frnp_next_addr #(
		.BLOCK_W(BLOCK_W),
		.PAGE_W(PAGE_W),
		.SECTOR_W(SECTOR_W)
	) u_next (
		.aux(buf_tag[TAG_W-1]),
		.spare(buf_tag[TAG_W-2]),
		.sector(buf_tag[SECTOR_W+PAGE_W+BLOCK_W-1:PAGE_W+BLOCK_W]),
		.page(buf_tag[PAGE_W+BLOCK_W-1:BLOCK_W]),
		.block(buf_tag[BLOCK_W-1:0]),
		.next_sector(pred_sector),
		.next_page(pred_page),
		.next_block(pred_block)
	);

	// Prediction keeps the aux and spare kind of the block in the buffer
	assign pred_tag = {buf_tag[TAG_W-1:TAG_W-2], pred_sector, pred_page, pred_block};

	assign buf_hit = buf_valid && (buf_tag == req_tag);
	assign la_hit = la_valid && (la_tag == req_tag);
	// Buffer keeps serving while the array works on the look-ahead block
	assign serve = rd_req && buf_hit;
	assign swap = rd_req && !buf_hit && la_hit && (state == frnp_pkg::FRNP_IDLE);
	// A request that also misses the block being fetched is a misprediction
	assign miss = rd_req && !buf_hit && !la_hit && !(state == frnp_pkg::FRNP_PREF && la_tag == req_tag);
	assign need_pref = buf_valid && !(la_tag == pred_tag && la_valid);

	assign busy = rd_req && !serve;

	always_comb
	begin
		next_state = state;
		unique case (state)
			frnp_pkg::FRNP_IDLE:
			begin
				if (miss)
				begin
					next_state = frnp_pkg::FRNP_DEMAND;
				end
				else if (need_pref && !swap)
				begin
					next_state = frnp_pkg::FRNP_PREF;
				end
			end
			frnp_pkg::FRNP_PREF:
			begin
				if (rd_done)
				begin
					next_state = miss ? frnp_pkg::FRNP_DEMAND : frnp_pkg::FRNP_IDLE;
				end
			end
			frnp_pkg::FRNP_DEMAND:
			begin
				if (rd_done)
				begin
					next_state = frnp_pkg::FRNP_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= frnp_pkg::FRNP_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// fixed array time bounds the miss
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 4'h0;
		end
		else if (next_state != state && next_state != frnp_pkg::FRNP_IDLE)
		begin
			cnt <= `FRNP_ARRAY_RD_CYC;
		end
		else if (cnt != 4'h0)
		begin
			cnt <= cnt - 4'h1;
		end
	end

	// Array address is launched with the state change so it is stable for the whole read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			arr_addr <= '0;
		end
		else if (next_state == frnp_pkg::FRNP_PREF && state != frnp_pkg::FRNP_PREF)
		begin
			arr_addr <= pred_tag;
		end
		else if (next_state == frnp_pkg::FRNP_DEMAND && state != frnp_pkg::FRNP_DEMAND)
		begin
			arr_addr <= req_tag;
		end
	end

	// Look-ahead holding register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			la_valid <= 1'b0;
			la_tag <= '0;
			la_data <= '0;
		end
		else if (state == frnp_pkg::FRNP_PREF && rd_done)
		begin
			la_valid <= 1'b1;
			la_tag <= arr_addr;
			la_data <= arr_rdata;
		end
		else if (next_state == frnp_pkg::FRNP_PREF && state != frnp_pkg::FRNP_PREF)
		begin
			// Tag tracks the block in flight so a matching request just waits for it
			la_valid <= 1'b0;
			la_tag <= pred_tag;
		end
		else if (swap || (state == frnp_pkg::FRNP_DEMAND && rd_done))
		begin
			la_valid <= 1'b0;
		end
	end

	// Block buffer, loaded by a demand read or by promoting the look-ahead
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			buf_valid <= 1'b0;
			buf_tag <= '0;
			buf_data <= '0;
		end
		else if (state == frnp_pkg::FRNP_DEMAND && rd_done)
		begin
			buf_valid <= 1'b1;
			buf_tag <= arr_addr;
			buf_data <= arr_rdata;
		end
		else if (swap)
		begin
			buf_valid <= 1'b1;
			buf_tag <= la_tag;
			buf_data <= la_data;
		end
	end

	assign word_sel = buf_data[req_word*DATA_W +: DATA_W];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stage_data <= '0;
			stage_valid <= 1'b0;
			rdata <= '0;
			rdata_valid <= 1'b0;
		end
		else
		begin
			stage_data <= word_sel;
			stage_valid <= serve;
			// Pipe mode adds one register stage; hold pipe_mode stable while reading
			rdata <= pipe_mode ? stage_data : word_sel;
			rdata_valid <= pipe_mode ? stage_valid : serve;
		end
	end

endmodule : frnp_lookahead

//--- rtl/frnp_next_addr.sv
// Look-ahead block address predictor for the flash block.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module frnp_next_addr #(
	parameter int BLOCK_W = 3,
	parameter int PAGE_W = 5,
	parameter int SECTOR_W = 6
) (
	input wire logic aux,
	input wire logic spare,
	input wire logic [SECTOR_W-1:0] sector,
	input wire logic [PAGE_W-1:0] page,
	input wire logic [BLOCK_W-1:0] block,
	output logic [SECTOR_W-1:0] next_sector,
	output logic [PAGE_W-1:0] next_page,
	output logic [BLOCK_W-1:0] next_block
);

	logic last_block;
	logic last_page;
	logic last_sector;

	assign last_block = &block;
	assign last_page = &page;
	assign last_sector = &sector;

	always_comb
	begin
		next_sector = sector;
		next_page = page;
		next_block = block;
		if (aux)
		begin
			next_page = page + 1'b1;
			if (last_page)
			begin
				next_sector = last_sector ? '0 : sector + 1'b1;
			end
		end
		else if (spare)
		begin
			next_block = '0;
			next_sector = last_sector ? '0 : sector + 1'b1;
		end
		else if (last_block)
		begin
			next_block = '0;
			next_page = page + 1'b1;
			if (last_page)
			begin
				next_sector = last_sector ? '0 : sector + 1'b1;
			end
		end
		else
		begin
			next_block = block + 1'b1;
		end
	end

endmodule : frnp_next_addr

//--- rtl/frnp_pkg.sv
// Types shared by the flash look-ahead read logic.
// No dependencies.
package frnp_pkg;

	typedef enum logic [2:0]
	{
		FRNP_IDLE = 3'b001,
		FRNP_PREF = 3'b010,
		FRNP_DEMAND = 3'b100
	} frnp_state_t;

endpackage : frnp_pkg

//--- rtl/frnp_regs.svh
// Timing counts and address field defaults for the flash look-ahead read logic.
// Included by frnp_lookahead only; holds definitions only.
`ifndef FRNP_REGS_SVH
`define FRNP_REGS_SVH

// Cycles one array block read occupies, start to data capture
`define FRNP_ARRAY_RD_CYC 4'h4
// Upper bound on busy cycles for a mispredicted request
`define FRNP_MISS_BUSY_MAX 4'h9

// Address field widths: word in block, block in page, page in sector, sector
`define FRNP_WORD_W 2
`define FRNP_BLOCK_W 3
`define FRNP_PAGE_W 5
`define FRNP_SECTOR_W 6
`define FRNP_DATA_W 32

`endif

//--- tb/flash_read_next_prefetch_tb.sv
// Self-checking bench for the flash look-ahead read sequencer.
// Drives the requester side; the array model answers at the far side.
`timescale 1ns/1ps
module flash_read_next_prefetch_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pipe_mode = 1'b0;
	logic rd_req = 1'b0;
	logic [17:0] req = 18'h0;
	logic busy, rdata_valid, arr_rd;
	logic [31:0] rdata;
	logic [15:0] arr_addr;
	logic [127:0] arr_rdata;
	int fails = 0;
	int check_count = 0;
	int seed = 32'h7e7a;
	logic [31:0] exp_q[$];
	// Third entry rereads the buffered block, so it is served while the look-ahead read runs
	logic [17:0] plan [7] = '{{2'h0, 6'h05, 5'h03, 3'h2, 2'h1}, {2'h0, 6'h05, 5'h03, 3'h3, 2'h2},
		{2'h0, 6'h05, 5'h03, 3'h3, 2'h0}, {2'h0, 6'h05, 5'h03, 3'h7, 2'h3},
		{2'h1, 6'h3f, 5'h00, 3'h0, 2'h0},
		{2'h2, 6'h3f, 5'h1f, 3'h0, 2'h2}, {2'h2, 6'h02, 5'h04, 3'h0, 2'h1}};

	always #50 clk = ~clk;

	frnp_lookahead dut (.clk(clk), .rst(rst), .pipe_mode(pipe_mode), .rd_req(rd_req),
		.req_aux(req[17]), .req_spare(req[16]), .req_sector(req[15:10]), .req_page(req[9:5]),
		.req_block(req[4:2]), .req_word(req[1:0]), .busy(busy), .rdata(rdata),
		.rdata_valid(rdata_valid), .arr_rd(arr_rd), .arr_addr(arr_addr), .arr_rdata(arr_rdata));
	frnp_array_model u_arr (.clk(clk), .arr_rd(arr_rd), .arr_addr(arr_addr), .arr_rdata(arr_rdata));

	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp_data

	task automatic cmp_addr(input logic [15:0] got, input logic [15:0] exp);
		cmp_data({16'h0, got}, {16'h0, exp});
	endtask : cmp_addr

	task automatic timed_out;
		fails++;
		$display("unexpected at %0t: wait ran out", $time);
		complete_run();
	endtask : timed_out

	function automatic logic [15:0] nxt(input logic [15:0] a);
		logic [13:0] f;
		f = a[13:0];
		if (a[15])
			f[13:3] = f[13:3] + 11'h1;
		else if (a[14])
			f = {f[13:8] + 6'h1, f[7:3], 3'h0};
		else
			f = f + 14'h1;
		return {a[15:14], f};
	endfunction : nxt

	task automatic rd(input logic [17:0] a, input bit chk);
		int n;
		n = 0;
		req <= a;
		rd_req <= 1'b1;
		@(negedge clk);
		while (busy !== 1'b0)
		begin
			n++;
			if (n > 20)
				timed_out();
			@(negedge clk);
		end
		@(posedge clk);
		exp_q.push_back({a[17:2], 14'h0, a[1:0]});
		rd_req <= 1'b0;
		if (chk)
		begin
			n = 0;
			@(negedge clk);
			while (!(arr_rd === 1'b1 && arr_addr !== a[17:2]))
			begin
				n++;
				if (n > 12)
					timed_out();
				@(negedge clk);
			end
			cmp_addr(arr_addr, nxt(a[17:2]));
		end
		@(posedge clk);
	endtask : rd

	always @(negedge clk)
	begin
		if (!rst && rdata_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				fails++;
				$display("unexpected at %0t: stray word", $time);
			end
			else
				cmp_data(rdata, exp_q.pop_front());
		end
	end

	initial
	begin
		logic [17:0] a;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int m = 0; m < 2; m++)
		begin
			repeat (12) @(posedge clk);
			pipe_mode <= m[0];
			@(posedge clk);
			foreach (plan[i])
				rd(plan[i], 1'b1);
			for (int k = 0; k < 6; k++)
			begin
				a = 18'($random(seed));
				a[16] = a[16] & ~a[17];
				rd(a, 1'b0);
			end
		end
		repeat (4) @(posedge clk);
		cmp_data(exp_q.size(), 32'h0);
		complete_run();
	end
endmodule : flash_read_next_prefetch_tb

bind frnp_lookahead frnp_lookahead_monitor u_mon (.clk(clk), .rst(rst), .pipe_mode(pipe_mode),
	.rd_req(rd_req), .busy(busy), .rdata_valid(rdata_valid), .arr_rd(arr_rd), .arr_addr(arr_addr));

//--- tb/frnp_array_model.sv
// Flash array model: a block pattern built from the address while a read stands.
// Outside reads the data lines churn, so stale data is never reused by luck.
`timescale 1ns/1ps
module frnp_array_model (
	input wire logic clk,
	input wire logic arr_rd,
	input wire logic [15:0] arr_addr,
	output logic [127:0] arr_rdata
);
	logic [31:0] noise = 32'h1;
	always_ff @(posedge clk)
		noise <= noise + 32'h9e37_79b9;
	always_comb
	begin
		for (int n = 0; n < 4; n++)
			arr_rdata[32*n+:32] = arr_rd ? {arr_addr, 14'h0, 2'(n)} : noise;
	end
endmodule : frnp_array_model

//--- tb/frnp_lookahead_monitor.sv
// Port assertions for the flash look-ahead read sequencer.
// Bound onto frnp_lookahead from the testbench top; one clock domain.
`timescale 1ns/1ps
module frnp_lookahead_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic pipe_mode,
	input wire logic rd_req,
	input wire logic busy,
	input wire logic rdata_valid,
	input wire logic arr_rd,
	input wire logic [15:0] arr_addr
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	busy_bound_a: assert property (rd_req && busy |-> ##[1:9] !busy)
		else $error("busy too long");
	// A running read only hands over to another without a gap when a miss waits
	switch_busy_a: assert property (arr_rd && $past(arr_rd) && !$stable(arr_addr) |-> busy)
		else $error("array switched with no pending miss");
	np_answer_a: assert property (rd_req && !busy && !pipe_mode |=> rdata_valid)
		else $error("no word in direct mode");
	pipe_answer_a: assert property (rd_req && !busy && pipe_mode |-> ##2 rdata_valid)
		else $error("no word in pipelined mode");
	valid_cause_a: assert property (rdata_valid && !pipe_mode |-> $past(rd_req) && !$past(busy))
		else $error("word without request");
	arr_span_a: assert property ($rose(arr_rd) |-> arr_rd [*4])
		else $error("array read cut short");
	arr_hold_a: assert property ($rose(arr_rd) |=> $stable(arr_addr) [*3])
		else $error("array address moved");
	miss_start_a: assert property (busy && !arr_rd |=> arr_rd || !busy)
		else $error("miss left array idle");
	cover property (rd_req && busy ##1 arr_rd);
	cover property (pipe_mode && rdata_valid);
	cover property ($rose(arr_rd) && !busy);
	cover property (arr_rd && rd_req && !busy);
endmodule : frnp_lookahead_monitor
